// ### core/fm_pkg.sv
package fm_pkg;
	// Register byte offsets on the APB slave
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_REF_CYCLES = 8'h08;
	localparam logic [7:0] OFS_REFFREQ = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_VALUE = 8'h14;
	localparam logic [7:0] OFS_FREQ = 8'h18;
	localparam logic [7:0] OFS_IFR = 8'h1C;
	localparam logic [7:0] OFS_IMR = 8'h20;

	// Field positions
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_EN_BIT = 1;
	localparam int MODE_REFSRC_LSB = 0;
	localparam int MODE_MSRSRC_LSB = 4;
	localparam int MODE_REFEN_BIT = 8;
	localparam int ST_MEAS_BIT = 0;
	localparam int ST_BUSY_BIT = 1;
	localparam int ST_GATED_BIT = 2;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_RDY_BIT = 1;

	// Widths
	localparam int SRC_N = 4;
	localparam int SEL_W = 2;
	localparam int REF_CYCLES_W = 16;
	localparam int VALUE_W = 24;
	localparam int IRQ_W = 2;
	localparam int DVD_W = 56;

	// Reset values
	localparam logic [REF_CYCLES_W-1:0] REF_CYCLES_RST = 16'h0000;
	localparam logic [31:0] REFFREQ_RST = 32'h0000_0000;
	localparam logic [IRQ_W-1:0] IMR_RST = 2'h0;

	// Cycles the reference gate takes to settle after a change, and cycles of the frequency divide
	localparam logic [3:0] RSW_CYC = 4'h4;
	localparam logic [5:0] DIV_CYC = 6'h38;

	typedef struct packed {
		logic ref_clock_enable;
		logic [SEL_W-1:0] measured_source_select;
		logic [SEL_W-1:0] ref_source_select;
	} fm_mode_t;

	typedef enum logic [1:0] {
		FM_IDLE = 2'b00,
		FM_RUN = 2'b01,
		FM_DIV = 2'b10
	} fm_state_t;
endpackage

// ### core/fm_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for asynchronous clock sources
module fm_sync #(
	parameter int W = 4
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	// First stage feeds only the second stage
	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;
endmodule

// ### core/fm_edge_cnt.sv
`timescale 1ns/1ps
// Counts rising edges of a synchronised clock level, saturating
module fm_edge_cnt #(
	parameter int W = 16
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clr,
	input wire logic en,
	input wire logic lvl,
	output logic [W-1:0] cnt
);
	logic prev_q;
	logic prev_d;
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	// Saturation keeps an overrun from wrapping to a small count
	always_comb begin
		prev_d = lvl;
		cnt_d = cnt_q;
		if (clr) begin
			cnt_d = '0;
		end else if (en && lvl && !prev_q && cnt_q != '1) begin
			cnt_d = cnt_q + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			prev_q <= 1'b0;
			cnt_q <= '0;
		end else begin
			prev_q <= prev_d;
			cnt_q <= cnt_d;
		end
	end

	assign cnt = cnt_q;
endmodule

// ### core/fm_top.sv
// Contract
// [R1] The reported frequency is the measured count over the reference cycle count times the reference frequency.
// [R2] A source select field in the mode register picks the reference clock and an enable bit gates it on.
// [R3] The reference clock and the measured clock each have their own set of selectable sources.
// [R4] Writing the reference enable bit sets the switching busy flag until the gating change completes.
// [R5] Software disables the reference clock before choosing another reference source.
// [R6] To change the reference, software clears enable, waits for not busy, reselects, sets enable and waits again.
// [R7] To start the reference, software selects the source, sets enable with other fields kept, then waits for not busy.
// [R8] A processor halt in debug mode does not freeze the meter.
// [R9] Software disables the meter before gating off its bus clock.
// [R10] The meter drives one interrupt request line.
// [R11] To disable the reference, software clears only the enable bit and waits for not busy.
// [R12] A measurement counts measured edges over the reference cycle count, stores the count and sets a done flag.
`timescale 1ns/1ps
module fm_top (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [fm_pkg::SRC_N-1:0] ref_src_clk,
	input wire logic [fm_pkg::SRC_N-1:0] msr_src_clk,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [fm_pkg::SRC_N-1:0] ref_sync;
	logic [fm_pkg::SRC_N-1:0] msr_sync;
	logic ref_lvl;
	logic msr_lvl;
	logic [fm_pkg::REF_CYCLES_W-1:0] ref_cnt;
	logic [fm_pkg::VALUE_W-1:0] msr_cnt;
	logic cnt_clr;
	logic cnt_en;

	logic en_q, en_d;
	fm_pkg::fm_mode_t mode_q, mode_d;
	logic [fm_pkg::REF_CYCLES_W-1:0] ref_cycles_q, ref_cycles_d;
	logic [31:0] reffreq_q, reffreq_d;
	logic [fm_pkg::IRQ_W-1:0] ifr_q, ifr_d;
	logic [fm_pkg::IRQ_W-1:0] imr_q, imr_d;
	logic [31:0] prdata_q, prdata_d;
	logic slverr_q, slverr_d;

	logic busy_q, busy_d;
	logic [3:0] bcnt_q, bcnt_d;
	logic gated_q, gated_d;

	fm_pkg::fm_state_t st_q, st_d;
	logic [fm_pkg::VALUE_W-1:0] value_q, value_d;
	logic [31:0] freq_q, freq_d;
	logic [fm_pkg::DVD_W-1:0] dvd_q, dvd_d;
	logic [fm_pkg::REF_CYCLES_W:0] rem_q, rem_d;
	logic [5:0] dcnt_q, dcnt_d;

	logic wr_acc;
	logic setup;
	logic mode_wr;
	logic start_req;
	logic ev_done;
	logic ev_rdy;
	logic [fm_pkg::REF_CYCLES_W:0] rem_sh;

	////////////////////////////////////////////////////////////////////////
	// Clock sources: synchronise every source before any logic sees it
	fm_sync #(.W(fm_pkg::SRC_N)) u_ref_sync (
		.core_clk(core_clk),
		.rst(rst),
		.async_in(ref_src_clk),
		.sync_out(ref_sync)
	);

	fm_sync #(.W(fm_pkg::SRC_N)) u_msr_sync (
		.core_clk(core_clk),
		.rst(rst),
		.async_in(msr_src_clk),
		.sync_out(msr_sync)
	);

	// Separate source sets; the reference only passes while gated on
	assign ref_lvl = ref_sync[mode_q.ref_source_select] & gated_q; // [R2] [R3]
	assign msr_lvl = msr_sync[mode_q.measured_source_select]; // [R3]

	fm_edge_cnt #(.W(fm_pkg::REF_CYCLES_W)) u_ref_cnt (
		.core_clk(core_clk),
		.rst(rst),
		.clr(cnt_clr),
		.en(cnt_en),
		.lvl(ref_lvl),
		.cnt(ref_cnt)
	);

	fm_edge_cnt #(.W(fm_pkg::VALUE_W)) u_msr_cnt (
		.core_clk(core_clk),
		.rst(rst),
		.clr(cnt_clr),
		.en(cnt_en),
		.lvl(msr_lvl),
		.cnt(msr_cnt)
	);

	////////////////////////////////////////////////////////////////////////
	// APB decode: writes land at the access edge, zero wait states
	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pwrite && !slverr_q;
	assign mode_wr = wr_acc && paddr == fm_pkg::OFS_MODE;
	assign start_req = wr_acc && paddr == fm_pkg::OFS_CTRL &&
		pwdata[fm_pkg::CTRL_START_BIT] && pwdata[fm_pkg::CTRL_EN_BIT];
	assign pready = psel && penable;
	assign pslverr = psel && penable && slverr_q;
	assign prdata = prdata_q;

	// Register file next values; hardware event set beats a W1C clear
	always_comb begin
		en_d = en_q;
		mode_d = mode_q;
		ref_cycles_d = ref_cycles_q;
		reffreq_d = reffreq_q;
		imr_d = imr_q;
		ifr_d = ifr_q;
		if (wr_acc) begin
			case (paddr)
				fm_pkg::OFS_CTRL: en_d = pwdata[fm_pkg::CTRL_EN_BIT];
				fm_pkg::OFS_MODE: begin
					mode_d.ref_clock_enable = pwdata[fm_pkg::MODE_REFEN_BIT];
					mode_d.measured_source_select =
						pwdata[fm_pkg::MODE_MSRSRC_LSB +: fm_pkg::SEL_W];
					// Source is frozen while the reference is on or switching
					if (!mode_q.ref_clock_enable && !busy_q) begin
						mode_d.ref_source_select =
							pwdata[fm_pkg::MODE_REFSRC_LSB +: fm_pkg::SEL_W]; // [R5]
					end
				end
				fm_pkg::OFS_REF_CYCLES:
					ref_cycles_d = pwdata[fm_pkg::REF_CYCLES_W-1:0];
				fm_pkg::OFS_REFFREQ: reffreq_d = pwdata;
				fm_pkg::OFS_IMR: imr_d = pwdata[fm_pkg::IRQ_W-1:0];
				fm_pkg::OFS_IFR: ifr_d = ifr_q & ~pwdata[fm_pkg::IRQ_W-1:0];
				default: begin
				end
			endcase
		end
		if (ev_done) begin
			ifr_d[fm_pkg::IRQ_DONE_BIT] = 1'b1; // [R12]
		end
		if (ev_rdy) begin
			ifr_d[fm_pkg::IRQ_RDY_BIT] = 1'b1;
		end
	end

	// Read data is captured in the setup phase so it comes from a flop
	always_comb begin
		prdata_d = prdata_q;
		slverr_d = slverr_q;
		if (setup) begin
			prdata_d = 32'h0000_0000;
			slverr_d = 1'b0;
			case (paddr)
				fm_pkg::OFS_CTRL: prdata_d[fm_pkg::CTRL_EN_BIT] = en_q;
				fm_pkg::OFS_MODE: begin
					prdata_d[fm_pkg::MODE_REFSRC_LSB +: fm_pkg::SEL_W] =
						mode_q.ref_source_select;
					prdata_d[fm_pkg::MODE_MSRSRC_LSB +: fm_pkg::SEL_W] =
						mode_q.measured_source_select;
					prdata_d[fm_pkg::MODE_REFEN_BIT] = mode_q.ref_clock_enable;
				end
				fm_pkg::OFS_REF_CYCLES:
					prdata_d[fm_pkg::REF_CYCLES_W-1:0] = ref_cycles_q;
				fm_pkg::OFS_REFFREQ: prdata_d = reffreq_q;
				fm_pkg::OFS_STATUS: begin
					prdata_d[fm_pkg::ST_MEAS_BIT] = st_q != fm_pkg::FM_IDLE;
					prdata_d[fm_pkg::ST_BUSY_BIT] = busy_q; // [R4]
					prdata_d[fm_pkg::ST_GATED_BIT] = gated_q;
				end
				fm_pkg::OFS_VALUE: prdata_d[fm_pkg::VALUE_W-1:0] = value_q;
				fm_pkg::OFS_FREQ: prdata_d = freq_q; // [R1]
				fm_pkg::OFS_IFR: prdata_d[fm_pkg::IRQ_W-1:0] = ifr_q;
				fm_pkg::OFS_IMR: prdata_d[fm_pkg::IRQ_W-1:0] = imr_q;
				default: slverr_d = 1'b1;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			en_q <= 1'b0;
			mode_q <= '0;
			ref_cycles_q <= fm_pkg::REF_CYCLES_RST;
			reffreq_q <= fm_pkg::REFFREQ_RST;
			imr_q <= fm_pkg::IMR_RST;
			ifr_q <= '0;
			prdata_q <= 32'h0000_0000;
			slverr_q <= 1'b0;
		end else begin
			en_q <= en_d;
			mode_q <= mode_d;
			ref_cycles_q <= ref_cycles_d;
			reffreq_q <= reffreq_d;
			imr_q <= imr_d;
			ifr_q <= ifr_d;
			prdata_q <= prdata_d;
			slverr_q <= slverr_d;
		end
	end

	// One level line toward the interrupt controller
	assign irq = |(ifr_q & imr_q); // [R10]

	////////////////////////////////////////////////////////////////////////
	// Reference gate switching; the gate moves only when busy expires
	always_comb begin
		busy_d = busy_q;
		bcnt_d = bcnt_q;
		gated_d = gated_q;
		ev_rdy = 1'b0;
		if (mode_wr) begin
			busy_d = 1'b1; // [R4]
			bcnt_d = fm_pkg::RSW_CYC;
		end else if (busy_q) begin
			if (bcnt_q == 4'h1) begin
				busy_d = 1'b0;
				gated_d = mode_q.ref_clock_enable; // [R2]
				ev_rdy = 1'b1;
			end else begin
				bcnt_d = bcnt_q - 4'h1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			busy_q <= 1'b0;
			bcnt_q <= 4'h0;
			gated_q <= 1'b0;
		end else begin
			busy_q <= busy_d;
			bcnt_q <= bcnt_d;
			gated_q <= gated_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Measurement and frequency division; no halt input exists, so a
	// debug stop of the processor never pauses this engine [R8]
	assign rem_sh = {rem_q[fm_pkg::REF_CYCLES_W-1:0],
		dvd_q[fm_pkg::DVD_W-1]};
	assign cnt_en = st_q == fm_pkg::FM_RUN;

	always_comb begin
		st_d = st_q;
		value_d = value_q;
		freq_d = freq_q;
		dvd_d = dvd_q;
		rem_d = rem_q;
		dcnt_d = dcnt_q;
		cnt_clr = 1'b0;
		ev_done = 1'b0;
		case (st_q)
			fm_pkg::FM_IDLE: begin
				// A zero cycle count or an ungated reference never starts
				if (start_req && gated_q && !busy_q && ref_cycles_q != '0) begin
					cnt_clr = 1'b1;
					st_d = fm_pkg::FM_RUN;
				end
			end
			fm_pkg::FM_RUN: begin
				if (!en_q) begin
					st_d = fm_pkg::FM_IDLE;
				end else if (ref_cnt >= ref_cycles_q) begin
					value_d = msr_cnt; // [R12]
					dvd_d = msr_cnt * reffreq_q;
					rem_d = '0;
					dcnt_d = fm_pkg::DIV_CYC;
					st_d = fm_pkg::FM_DIV;
				end
			end
			fm_pkg::FM_DIV: begin
				// Restoring divide, one quotient bit per cycle
				if (rem_sh >= {1'b0, ref_cycles_q}) begin
					rem_d = rem_sh - {1'b0, ref_cycles_q};
					dvd_d = {dvd_q[fm_pkg::DVD_W-2:0], 1'b1};
				end else begin
					rem_d = rem_sh;
					dvd_d = {dvd_q[fm_pkg::DVD_W-2:0], 1'b0};
				end
				dcnt_d = dcnt_q - 6'h01;
				if (dcnt_q == 6'h01) begin
					// Saturate rather than report a wrapped value
					freq_d = |dvd_d[fm_pkg::DVD_W-1:32] ? 32'hFFFF_FFFF :
						dvd_d[31:0]; // [R1]
					ev_done = 1'b1; // [R12]
					st_d = fm_pkg::FM_IDLE;
				end
			end
			default: st_d = fm_pkg::FM_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_q <= fm_pkg::FM_IDLE;
			value_q <= '0;
			freq_q <= 32'h0000_0000;
			dvd_q <= '0;
			rem_q <= '0;
			dcnt_q <= 6'h00;
		end else begin
			st_q <= st_d;
			value_q <= value_d;
			freq_q <= freq_d;
			dvd_q <= dvd_d;
			rem_q <= rem_d;
			dcnt_q <= dcnt_d;
		end
	end
endmodule

// ### dv/fm_chk.sv
`timescale 1ns/1ps
module fm_chk (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic wr;
	logic rds;
	logic [3:0] age_q;
	logic en_q;
	logic [1:0] ms_q;
	assign wr = psel && penable && pwrite;
	assign rds = psel && !penable && !pwrite && paddr == fm_pkg::OFS_STATUS;
	// Age since last mode write; saturates so a long idle reads as settled
	always_ff @(posedge core_clk) begin
		if (rst) begin
			age_q <= 4'hF;
			en_q <= 1'b0;
			ms_q <= 2'h0;
		end else if (wr && paddr == fm_pkg::OFS_MODE) begin
			age_q <= 4'h0;
			en_q <= pwdata[8];
			ms_q <= pwdata[5:4];
		end else if (age_q != 4'hF) begin
			age_q <= age_q + 4'h1;
		end
	end
	a_ready_access: assert property (psel && penable |-> pready)
		else $error("pready missing in access");
	a_ready_idle: assert property (!penable |-> !pready && !pslverr)
		else $error("answer outside access");
	a_err_unmapped: assert property (penable && paddr > 8'h20 |-> pslverr)
		else $error("unmapped access not refused");
	a_busy_on_write: assert property (
		wr && paddr == fm_pkg::OFS_MODE ##1 rds |=> prdata[1])
		else $error("busy not set by mode write");
	a_busy_clears: assert property (rds && age_q >= 4'h7 |=> !prdata[1])
		else $error("busy stuck");
	a_gate_follows: assert property (
		rds && age_q >= 4'h7 |=> prdata[2] == en_q)
		else $error("gate differs from enable");
	a_msr_kept: assert property (
		psel && !penable && paddr == fm_pkg::OFS_MODE |=> prdata[5:4] == ms_q)
		else $error("measured select lost");
	a_irq_masked: assert property (
		wr && paddr == fm_pkg::OFS_IMR && pwdata[1:0] == 2'h0 |=> !irq [*2])
		else $error("irq with all masked");
endmodule
////////////////////////////////////////////////////////////////////////////
bind fm_top fm_chk u_fm_chk (.core_clk(core_clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// ### dv/fm_top_tb.sv
`timescale 1ns/1ps
module fm_top_tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic err;
	logic pready;
	logic pslverr;
	logic irq;
	logic [7:0] paddr = 8'h00;
	logic [7:0] cyc = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rd;
	logic [31:0] prdata;
	logic [3:0] rclk = 4'h0;
	logic [3:0] mclk = 4'h0;
	int fail_count = 0;
	int comparisons = 0;
	always #20 core_clk = ~core_clk;
	// Reference sources 1 and 3 and measured sources 0 and 2 run, at different rates, so a wrong pick shows
	always @(posedge core_clk) begin
		cyc <= cyc + 8'h01;
		rclk <= {cyc[2], 1'b0, cyc[3], 1'b0};
		mclk <= {1'b0, cyc[2], 1'b0, cyc[4]};
	end
	fm_top u_fm_top (.core_clk(core_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ref_src_clk(rclk), .msr_src_clk(mclk), .irq(irq));
	////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task results;
		$display("mismatches=%0d checks=%0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Leaves psel high so a following transfer may start at once
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// No wait count is assumed; a hung slave is left to the watchdog
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
	endtask
	task idle(input int n);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (n) @(posedge core_clk);
	endtask
	task poll(input logic [7:0] a, input int b, input logic v);
		int k;
		k = 0;
		do begin
			apb(1'b0, a, 32'h0);
			k++;
		end while (rd[b] !== v && k < 300);
		chk(32'(rd[b]), 32'(v));
	endtask
	////////////////////////////////////////////////////////////////////
	// Every register, the frequency word too, reads zero after reset
	task t_reset;
		for (int i = 0; i < 9; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk(rd, 32'h0);
			chk(32'(err), 32'h0);
		end
	endtask
	task t_bad;
		apb(1'b1, 8'h40, 32'hFFFF_FFFF);
		chk(32'(err), 32'h1);
		apb(1'b0, 8'h40, 32'h0);
		chk({rd[30:0], err}, 32'h1);
	endtask
	task t_ref;
		apb(1'b1, fm_pkg::OFS_MODE, 32'h21);
		poll(fm_pkg::OFS_STATUS, 1, 1'b0);
		apb(1'b1, fm_pkg::OFS_MODE, 32'h121);
		apb(1'b0, fm_pkg::OFS_STATUS, 32'h0);
		chk(32'(rd[1]), 32'h1);
		poll(fm_pkg::OFS_STATUS, 1, 1'b0);
		chk(32'(rd[2]), 32'h1);
		apb(1'b1, fm_pkg::OFS_IMR, 32'h2);
		idle(1);
		chk(32'(irq), 32'h1);
		// A pending flag stays silent while its mask bit is clear
		apb(1'b1, fm_pkg::OFS_IMR, 32'h0);
		idle(1);
		chk(32'(irq), 32'h0);
		apb(1'b1, fm_pkg::OFS_IMR, 32'h2);
		apb(1'b1, fm_pkg::OFS_IFR, 32'h2);
		idle(1);
		chk(32'(irq), 32'h0);
		// Source change with the gate on must be dropped
		apb(1'b1, fm_pkg::OFS_MODE, 32'h123);
		apb(1'b0, fm_pkg::OFS_MODE, 32'h0);
		chk(rd, 32'h121);
		poll(fm_pkg::OFS_STATUS, 1, 1'b0);
	endtask
	task t_meas;
		logic [31:0] v;
		apb(1'b1, fm_pkg::OFS_REF_CYCLES, 32'h8);
		apb(1'b1, fm_pkg::OFS_REFFREQ, 32'h3E8);
		apb(1'b1, fm_pkg::OFS_IMR, 32'h1);
		apb(1'b1, fm_pkg::OFS_CTRL, 32'h3);
		poll(fm_pkg::OFS_IFR, 0, 1'b1);
		chk(32'(irq), 32'h1);
		apb(1'b0, fm_pkg::OFS_VALUE, 32'h0);
		v = rd;
		// Measured runs at twice the reference rate; the start phase
		// against the first reference edge costs up to two edges
		chk(32'(v >= 32'hE && v <= 32'h10), 32'h1);
		apb(1'b0, fm_pkg::OFS_FREQ, 32'h0);
		chk(rd, v * 32'h3E8 / 32'h8);
		apb(1'b0, fm_pkg::OFS_STATUS, 32'h0);
		chk(32'(rd[0]), 32'h0);
		apb(1'b1, fm_pkg::OFS_IFR, 32'h1);
		idle(1);
		chk(32'(irq), 32'h0);
	endtask
	task t_off;
		apb(1'b1, fm_pkg::OFS_MODE, 32'h21);
		poll(fm_pkg::OFS_STATUS, 1, 1'b0);
		chk(32'(rd[2]), 32'h0);
		apb(1'b1, fm_pkg::OFS_MODE, 32'h23);
		poll(fm_pkg::OFS_STATUS, 1, 1'b0);
		apb(1'b1, fm_pkg::OFS_MODE, 32'h123);
		poll(fm_pkg::OFS_STATUS, 1, 1'b0);
		apb(1'b0, fm_pkg::OFS_MODE, 32'h0);
		chk(rd, 32'h123);
		// Meter is switched off mid-run, as before its bus clock is gated
		apb(1'b1, fm_pkg::OFS_CTRL, 32'h3);
		apb(1'b0, fm_pkg::OFS_STATUS, 32'h0);
		chk(32'(rd[0]), 32'h1);
		apb(1'b1, fm_pkg::OFS_CTRL, 32'h0);
		idle(1);
		apb(1'b0, fm_pkg::OFS_STATUS, 32'h0);
		chk(32'(rd[0]), 32'h0);
		idle(1);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		#2000000;
		fail_count++;
		results;
	end
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		t_reset;
		t_bad;
		t_ref;
		t_meas;
		t_off;
		results;
	end
endmodule
